/* hdl/scg_pkg.sv */
/*
  Constants of the system clock generation unit: strap field layout,
  rate-mode encodings, reset values and divider codes.
  Assumes a single 40 MHz control clock drives every user of this package.
*/
package scg_pkg;

  // ----------------------------------------
  // Reset configuration word low layout
  // ----------------------------------------
  localparam int RCW_LOCAL_BUS_CLOCK_MODE_BIT = 31;
  localparam int RCW_MEMORY_CLOCK_MODE_BIT = 30;
  localparam int RCW_SYSTEM_VCO_DIVIDER_LSB = 28;
  localparam int RCW_SYSTEM_PLL_MULTIPLIER_LSB = 24;
  localparam int RCW_CORE_PLL_MULTIPLIER_LSB = 16;
  localparam int SYSTEM_PLL_MULTIPLIER_W = 4;
  localparam int CORE_PLL_MULTIPLIER_W = 7;
  localparam int RATIO_W = 5;

  // ----------------------------------------
  // System multiplier codes
  // ----------------------------------------
  localparam logic [SYSTEM_PLL_MULTIPLIER_W-1:0] SYSTEM_PLL_MULTIPLIER_MIN_LEGAL = 4'h2;

  // ----------------------------------------
  // Peripheral rate modes
  // ----------------------------------------
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_FULL = 2'h1;
  localparam logic [1:0] MODE_HALF = 2'h2;
  localparam logic [1:0] MODE_THIRD = 2'h3;
  localparam logic [1:0] MODE_RESET_DEFAULT = MODE_THIRD;
  localparam logic [1:0] MODE_RESET_PCI = MODE_FULL;

  // ----------------------------------------
  // Local bus divider codes (half periods)
  // ----------------------------------------
  localparam logic [1:0] LBDIV_2 = 2'h0;
  localparam logic [1:0] LBDIV_4 = 2'h1;
  localparam logic [1:0] LBDIV_8 = 2'h2;
  localparam logic [2:0] LB_HALF_2 = 3'h1;
  localparam logic [2:0] LB_HALF_4 = 3'h2;
  localparam logic [2:0] LB_HALF_8 = 3'h4;

endpackage : scg_pkg

/* hdl/scg_unit_div.sv */
/*
  One peripheral clock divider: emits a one-cycle tick per unit period,
  at full, half or third of the system bus tick rate, or none when off.
  Assumes csb_tick_in is a single-cycle pulse on mclk_in.
*/
`timescale 1ns/1ps
module scg_unit_div
  import scg_pkg::*;
#(
  parameter logic [1:0] RESET_MODE = MODE_RESET_DEFAULT,
  parameter bit FULL_ONLY = 1'b0
) (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic resetn_in,
  // Control
  input wire logic csb_tick_in,
  input wire logic [1:0] mode_in,
  // Result
  output logic unit_tick_out,
  output logic [1:0] mode_out
);

  logic [1:0] count_ff;
  logic [1:0] mode_ff;
  logic tick_ff;
  logic [1:0] nxt_mode;

  function automatic logic [1:0] reload(input logic [1:0] m);
    unique case (m)
      MODE_HALF: reload = 2'h1;
      MODE_THIRD: reload = 2'h2;
      default: reload = 2'h0;
    endcase
  endfunction : reload

  // Restricted units keep their mode on an illegal request
  always_comb begin
    nxt_mode = mode_in;
    if (FULL_ONLY && (mode_in == MODE_HALF || mode_in == MODE_THIRD)) begin
      nxt_mode = mode_ff;
    end
  end

  // ----------------------------------------
  // Period counter
  // ----------------------------------------
  // switch only at boundary
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      count_ff <= 2'h0;
      mode_ff <= RESET_MODE;
      tick_ff <= 1'b0;
    end else if (csb_tick_in) begin
      if (count_ff == 2'h0) begin
        mode_ff <= nxt_mode;
        count_ff <= reload(nxt_mode);
        tick_ff <= (nxt_mode != MODE_OFF);
      end else begin
        count_ff <= count_ff - 2'h1;
        tick_ff <= 1'b0;
      end
    end else begin
      tick_ff <= 1'b0;
    end
  end

  assign unit_tick_out = tick_ff;
  assign mode_out = mode_ff;

  mode_boundary_a: assert property (
    @(posedge mclk_in) disable iff (!resetn_in)
    $changed(mode_ff) |-> $past(csb_tick_in) && ($past(count_ff) == 2'h0))
    else $error("unit mode changed inside a period");

  full_only_a: assert property (
    @(posedge mclk_in) disable iff (!resetn_in)
    FULL_ONLY |-> (mode_ff == MODE_OFF || mode_ff == MODE_FULL))
    else $error("restricted unit left off or full rate");

endmodule : scg_unit_div

/* hdl/scg_top.sv */
/*
  System clock generation unit, modelled on one control clock: primary
  clock choice, sync and bus clock outputs, ratio results from reset
  straps, memory and local bus clocks, peripheral rate dividers.
  Assumes mclk_in stands for the fastest internal clock (twice the system
  bus rate); derived clocks are shown as ticks and toggled levels.
*/
`timescale 1ns/1ps
module scg_top
  import scg_pkg::*;
#(
  parameter int NUM_BUS_OUT = 3,
  parameter int NUM_UNITS = 6,
  parameter int PCI_UNIT_IDX = 4,
  parameter int NUM_LB_OUT = 3
) (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic resetn_in,
  // Straps
  input wire logic host_mode_in,
  input wire logic ref_halve_select_in,
  input wire logic [31:0] reset_config_word_low_in,
  // Clock pins
  input wire logic host_ref_clock_in,
  input wire logic pci_bus_clock_in,
  input wire logic sync_clock_in,
  // Control
  input wire logic [NUM_BUS_OUT-1:0] bus_clock_out_enable_n_in,
  input wire logic [1:0] local_bus_divider_in,
  input wire logic [2*NUM_UNITS-1:0] peripheral_clock_ctrl_reg_in,
  // Primary and bus clocks
  output logic primary_clock_out,
  output logic sync_clock_out,
  output logic sync_seen_out,
  output logic [NUM_BUS_OUT-1:0] bus_clock_out_n,
  // Ratios
  output logic cfg_loaded_out,
  output logic system_pll_multiplier_reserved_out,
  output logic [RATIO_W-1:0] csb_ratio_out,
  output logic [CORE_PLL_MULTIPLIER_W-1:0] core_pll_multiplier_out,
  // Derived clocks
  output logic csb_tick_out,
  output logic ddr_tick_out,
  output logic ddr_data_strobe_out,
  output logic memory_clock_out,
  output logic memory_clock_out_b,
  output logic lbiu_tick_out,
  output logic [NUM_LB_OUT-1:0] local_bus_clock_out,
  output logic [NUM_UNITS-1:0] unit_tick_out
);

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!resetn_in);

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [2:0] pin_s1_ff, pin_s2_ff;
  logic [33:0] strap_s1_ff, strap_s2_ff;

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pin_s1_ff <= 3'h0;
      pin_s2_ff <= 3'h0;
      strap_s1_ff <= 34'h0;
      strap_s2_ff <= 34'h0;
    end else begin
      pin_s1_ff <= {sync_clock_in, pci_bus_clock_in, host_ref_clock_in};
      pin_s2_ff <= pin_s1_ff;
      strap_s1_ff <= {host_mode_in, ref_halve_select_in, reset_config_word_low_in};
      strap_s2_ff <= strap_s1_ff;
    end
  end

  // ----------------------------------------
  // Strap capture after reset release
  // ----------------------------------------
  // Two edges of settling so the captured word has crossed the synchroniser
  logic [1:0] settle_ff;
  logic cfg_loaded_ff, host_mode_ff, halve_ff, memory_clock_mode_ff, local_bus_clock_mode_ff;
  logic [SYSTEM_PLL_MULTIPLIER_W-1:0] system_pll_multiplier_ff;
  logic [CORE_PLL_MULTIPLIER_W-1:0] core_pll_multiplier_ff;

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      settle_ff <= 2'h0;
      cfg_loaded_ff <= 1'b0;
      host_mode_ff <= 1'b0;
      halve_ff <= 1'b0;
      memory_clock_mode_ff <= 1'b0;
      local_bus_clock_mode_ff <= 1'b0;
      system_pll_multiplier_ff <= 4'h0;
      core_pll_multiplier_ff <= 7'h00;
    end else if (!cfg_loaded_ff) begin
      settle_ff <= settle_ff + 2'h1;
      if (settle_ff == 2'h2) begin
        cfg_loaded_ff <= 1'b1;
        host_mode_ff <= strap_s2_ff[33];
        halve_ff <= strap_s2_ff[32];
        memory_clock_mode_ff <= strap_s2_ff[RCW_MEMORY_CLOCK_MODE_BIT];
        local_bus_clock_mode_ff <= strap_s2_ff[RCW_LOCAL_BUS_CLOCK_MODE_BIT];
        system_pll_multiplier_ff <= strap_s2_ff[RCW_SYSTEM_PLL_MULTIPLIER_LSB +: SYSTEM_PLL_MULTIPLIER_W];
        core_pll_multiplier_ff <= strap_s2_ff[RCW_CORE_PLL_MULTIPLIER_LSB +: CORE_PLL_MULTIPLIER_W];
      end
    end
  end

  // ----------------------------------------
  // Ratio results
  // ----------------------------------------
  logic reserved_ff;
  logic [RATIO_W-1:0] ratio_ff;
  logic [CORE_PLL_MULTIPLIER_W-1:0] core_ff;

  // reserved codes give no ratio; ratio equation
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      reserved_ff <= 1'b0;
      ratio_ff <= 5'h00;
      core_ff <= 7'h00;
    end else begin
      reserved_ff <= cfg_loaded_ff && (system_pll_multiplier_ff < SYSTEM_PLL_MULTIPLIER_MIN_LEGAL);
      core_ff <= core_pll_multiplier_ff;
      if (!cfg_loaded_ff || system_pll_multiplier_ff < SYSTEM_PLL_MULTIPLIER_MIN_LEGAL) begin
        ratio_ff <= 5'h00;
      end else begin
        ratio_ff <= halve_ff ? {system_pll_multiplier_ff, 1'b0} : {1'b0, system_pll_multiplier_ff};
      end
    end
  end

  // ----------------------------------------
  // Primary, sync and bus clock outputs
  // ----------------------------------------
  logic primary_ff, sync_ff, seen_ff, sync_in_d_ff;
  logic [NUM_BUS_OUT-1:0] bus_ff;

  // role selects source; whole or halved
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      primary_ff <= 1'b0;
      sync_ff <= 1'b0;
    end else if (cfg_loaded_ff) begin
      primary_ff <= host_mode_ff ? pin_s2_ff[0] : pin_s2_ff[1];
      if (!host_mode_ff) begin
        sync_ff <= 1'b0;
      end else if (!halve_ff) begin
        sync_ff <= primary_ff;
      end else if (!primary_ff && (pin_s2_ff[0])) begin
        sync_ff <= ~sync_ff;
      end
    end
  end

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      bus_ff <= '0;
    end else begin
      bus_ff <= bus_clock_out_enable_n_in & {NUM_BUS_OUT{sync_ff}};
    end
  end

  // loopback seen once the sync input moves
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sync_in_d_ff <= 1'b0;
      seen_ff <= 1'b0;
    end else begin
      sync_in_d_ff <= pin_s2_ff[2];
      if (pin_s2_ff[2] != sync_in_d_ff) begin
        seen_ff <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Bus, memory and local bus clocks
  // ----------------------------------------
  logic phase_ff, csb_ff, ddr_ff, mck_ff, mck_b_ff, lbiu_ff;
  logic [NUM_LB_OUT-1:0] local_bus_clock_out_ff;
  logic [2:0] lb_cnt_ff;
  logic nxt_csb, nxt_ddr, nxt_lbiu;

  function automatic logic [2:0] lb_half(input logic [1:0] code);
    unique case (code)
      LBDIV_2: lb_half = LB_HALF_2;
      LBDIV_4: lb_half = LB_HALF_4;
      default: lb_half = LB_HALF_8;
    endcase
  endfunction : lb_half

  assign nxt_csb = cfg_loaded_ff && phase_ff;
  // memory clock one or two times bus clock
  assign nxt_ddr = cfg_loaded_ff && (memory_clock_mode_ff || phase_ff);
  // local bus unit one or two times bus clock
  assign nxt_lbiu = cfg_loaded_ff && (local_bus_clock_mode_ff || phase_ff);

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      phase_ff <= 1'b0;
      csb_ff <= 1'b0;
      ddr_ff <= 1'b0;
      lbiu_ff <= 1'b0;
    end else begin
      phase_ff <= cfg_loaded_ff && !phase_ff;
      csb_ff <= nxt_csb;
      ddr_ff <= nxt_ddr;
      lbiu_ff <= nxt_lbiu;
    end
  end

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      mck_ff <= 1'b0;
    end else if (nxt_ddr) begin
      mck_ff <= ~mck_ff;
    end
  end

  // complement leg kept in its own flop, no gate on the pin
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      mck_b_ff <= 1'b1;
    end else if (nxt_ddr) begin
      mck_b_ff <= mck_ff;
    end
  end

  // divide by 2, 4 or 8
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      lb_cnt_ff <= 3'h0;
      local_bus_clock_out_ff <= '0;
    end else if (nxt_lbiu) begin
      if (lb_cnt_ff + 3'h1 >= lb_half(local_bus_divider_in)) begin
        lb_cnt_ff <= 3'h0;
        local_bus_clock_out_ff <= ~local_bus_clock_out_ff;
      end else begin
        lb_cnt_ff <= lb_cnt_ff + 3'h1;
      end
    end
  end

  // ----------------------------------------
  // Peripheral dividers
  // ----------------------------------------
  logic [NUM_UNITS-1:0] unit_tick;
  logic [2*NUM_UNITS-1:0] unit_mode;

  for (genvar u = 0; u < NUM_UNITS; u++) begin : g_unit
    scg_unit_div #(
      .RESET_MODE(u == PCI_UNIT_IDX ? MODE_RESET_PCI : MODE_RESET_DEFAULT),
      .FULL_ONLY(u == PCI_UNIT_IDX)
    ) u_div (
      .mclk_in(mclk_in),
      .resetn_in(resetn_in),
      .csb_tick_in(csb_ff),
      .mode_in(peripheral_clock_ctrl_reg_in[2*u +: 2]),
      .unit_tick_out(unit_tick[u]),
      .mode_out(unit_mode[2*u +: 2])
    );
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign primary_clock_out = primary_ff;
  assign sync_clock_out = sync_ff;
  assign sync_seen_out = seen_ff;
  assign bus_clock_out_n = bus_ff;
  assign cfg_loaded_out = cfg_loaded_ff;
  assign system_pll_multiplier_reserved_out = reserved_ff;
  assign csb_ratio_out = ratio_ff;
  assign core_pll_multiplier_out = core_ff;
  assign csb_tick_out = csb_ff;
  assign ddr_tick_out = ddr_ff;
  // data strobe at memory controller rate
  assign ddr_data_strobe_out = ddr_ff;
  assign memory_clock_out = mck_ff;
  assign memory_clock_out_b = mck_b_ff;
  assign lbiu_tick_out = lbiu_ff;
  assign local_bus_clock_out = local_bus_clock_out_ff;
  assign unit_tick_out = unit_tick;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence loaded_s;
    cfg_loaded_ff ##1 cfg_loaded_ff;
  endsequence

  primary_select_a: assert property (
    loaded_s |=> primary_clock_out == $past(host_mode_ff ? pin_s2_ff[0] : pin_s2_ff[1]))
    else $error("primary clock from wrong source");

  sync_halve_a: assert property (
    host_mode_ff && halve_ff && $changed(sync_clock_out) |->
    $past(pin_s2_ff[0]) && !$past(primary_ff))
    else $error("halved sync moved without a reference rise");

  bus_gate_a: assert property (
    (bus_clock_out_n & ~$past(bus_clock_out_enable_n_in)) == '0)
    else $error("disabled bus clock output driven");

  csb_ratio_a: assert property (
    cfg_loaded_ff && system_pll_multiplier_ff >= SYSTEM_PLL_MULTIPLIER_MIN_LEGAL |=>
    csb_ratio_out == RATIO_W'(system_pll_multiplier_ff) * (RATIO_W'(halve_ff) + 5'h01))
    else $error("bus ratio not equal to equation");

  core_mult_a: assert property (
    cfg_loaded_ff |-> ##1 core_pll_multiplier_out == $past(core_pll_multiplier_ff) ##1 $stable(core_pll_multiplier_ff))
    else $error("core multiplier not from the reset word");

  ddr_rate_a: assert property (
    csb_tick_out |-> ddr_tick_out ##1 (ddr_tick_out == memory_clock_mode_ff))
    else $error("memory controller rate wrong");

  mck_pair_a: assert property (
    $changed(memory_clock_out) |-> ddr_tick_out && (memory_clock_out_b != memory_clock_out))
    else $error("memory clock pair toggled off a tick");

  data_rate_a: assert property (
    ddr_data_strobe_out == ddr_tick_out)
    else $error("data strobe not at controller rate");

  lb_div2_a: assert property (
    $changed(local_bus_clock_out_ff[0]) && !local_bus_clock_mode_ff && $past(local_bus_divider_in) == LBDIV_2
    && $stable(local_bus_divider_in) |-> ##1 $stable(local_bus_clock_out_ff[0]) ##1 $changed(local_bus_clock_out_ff[0]))
    else $error("local bus clock not divided by two");

  reserved_code_a: assert property (
    cfg_loaded_ff && system_pll_multiplier_ff < SYSTEM_PLL_MULTIPLIER_MIN_LEGAL |=> system_pll_multiplier_reserved_out && csb_ratio_out == '0)
    else $error("reserved multiplier code accepted");

  reset_rate_a: assert property (
    $rose(cfg_loaded_ff) |-> unit_mode[2*PCI_UNIT_IDX +: 2] != MODE_HALF)
    else $error("restricted unit at half rate");

endmodule : scg_top

/* verification/scg_clk_partner.sv */
/*
  Board-side model: reference and bus clock sources plus the sync loopback.
  Assumes the bench clock mclk_in; all pins change on its falling edge.
*/
`timescale 1ns/1ps
module scg_clk_partner #(
  parameter int REF_HALF = 8,
  parameter int PCI_HALF = 5
) (
  // Clock and role
  input wire logic mclk_in,
  input wire logic host_mode_in,
  // Loopback
  input wire logic sync_out_in,
  output logic sync_loop_out,
  // Sources
  output logic ref_clk_out,
  output logic pci_clk_out
);
  // ----------------------------------------
  // Free-running sources
  // ----------------------------------------
  int ref_cnt = 0;
  int pci_cnt = 0;
  logic ref_lvl = 1'b0;
  logic [1:0] loop_ff = 2'h0;
  initial pci_clk_out = 1'b0;
  always @(negedge mclk_in) begin
    ref_cnt = (ref_cnt == REF_HALF - 1) ? 0 : ref_cnt + 1;
    pci_cnt = (pci_cnt == PCI_HALF - 1) ? 0 : pci_cnt + 1;
    if (ref_cnt == 0) ref_lvl = ~ref_lvl;
    if (pci_cnt == 0) pci_clk_out <= ~pci_clk_out;
  end
  // Agent role: reference pin tied to ground
  assign ref_clk_out = host_mode_in & ref_lvl;
  // ----------------------------------------
  // Loopback
  // ----------------------------------------
  // equal fixed trace delay
  always @(negedge mclk_in) loop_ff <= {loop_ff[0], sync_out_in};
  assign sync_loop_out = loop_ff[1];
endmodule : scg_clk_partner

/* verification/system_clock_generation_tb_top.sv */
/*
  Self-checking bench for the clock generation unit with board partner.
  Assumes default top parameters: 3 bus outputs, 6 units, unit 4 full only.
*/
`timescale 1ns/1ps
module system_clock_generation_tb_top;
  import scg_pkg::*;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic mclk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic host_mode_in = 1'b1;
  logic ref_halve_select_in = 1'b0;
  logic [31:0] reset_config_word_low_in = 32'h0;
  logic host_ref_clock_in, pci_bus_clock_in, sync_clock_in;
  logic [2:0] bus_clock_out_enable_n_in = 3'h1;
  logic [1:0] local_bus_divider_in = 2'h0;
  logic [11:0] peripheral_clock_ctrl_reg_in = 12'hfff;
  logic primary_clock_out, sync_clock_out, sync_seen_out, cfg_loaded_out;
  logic system_pll_multiplier_reserved_out, csb_tick_out, ddr_tick_out, ddr_data_strobe_out;
  logic memory_clock_out, memory_clock_out_b, lbiu_tick_out;
  logic [2:0] bus_clock_out_n, local_bus_clock_out;
  logic [4:0] csb_ratio_out;
  logic [6:0] core_pll_multiplier_out;
  logic [5:0] unit_tick_out;
  logic [15:0] watch;
  int n_mismatch = 0;
  int tests_run = 0;
  int cycles = 0;
  assign watch = {unit_tick_out, lbiu_tick_out, ddr_data_strobe_out, ddr_tick_out,
                  csb_tick_out, local_bus_clock_out[0], memory_clock_out,
                  bus_clock_out_n[1:0], sync_clock_out, primary_clock_out};
  // ----------------------------------------
  // Design and partner
  // ----------------------------------------
  scg_top dut (.mclk_in(mclk_in), .resetn_in(resetn_in), .host_mode_in(host_mode_in),
    .ref_halve_select_in(ref_halve_select_in),
    .reset_config_word_low_in(reset_config_word_low_in),
    .host_ref_clock_in(host_ref_clock_in), .pci_bus_clock_in(pci_bus_clock_in),
    .sync_clock_in(sync_clock_in), .bus_clock_out_enable_n_in(bus_clock_out_enable_n_in),
    .local_bus_divider_in(local_bus_divider_in),
    .peripheral_clock_ctrl_reg_in(peripheral_clock_ctrl_reg_in),
    .primary_clock_out(primary_clock_out), .sync_clock_out(sync_clock_out),
    .sync_seen_out(sync_seen_out), .bus_clock_out_n(bus_clock_out_n),
    .cfg_loaded_out(cfg_loaded_out), .system_pll_multiplier_reserved_out(system_pll_multiplier_reserved_out),
    .csb_ratio_out(csb_ratio_out), .core_pll_multiplier_out(core_pll_multiplier_out),
    .csb_tick_out(csb_tick_out), .ddr_tick_out(ddr_tick_out),
    .ddr_data_strobe_out(ddr_data_strobe_out), .memory_clock_out(memory_clock_out),
    .memory_clock_out_b(memory_clock_out_b), .lbiu_tick_out(lbiu_tick_out),
    .local_bus_clock_out(local_bus_clock_out), .unit_tick_out(unit_tick_out));
  scg_clk_partner #(.REF_HALF(8), .PCI_HALF(5)) partner (.mclk_in(mclk_in),
    .host_mode_in(host_mode_in), .sync_out_in(sync_clock_out),
    .sync_loop_out(sync_clock_in), .ref_clk_out(host_ref_clock_in),
    .pci_clk_out(pci_bus_clock_in));
  // ----------------------------------------
  // Clock, timeout and helpers
  // ----------------------------------------
  initial forever #12.5 mclk_in = ~mclk_in;
  always @(posedge mclk_in) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_mismatch = n_mismatch + 1;
      tally_and_finish();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run = tests_run + 1;
    if (seen !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check
  task automatic apply_reset(input logic host, input logic halve, input logic [31:0] word);
    @(negedge mclk_in);
    resetn_in = 1'b0;
    host_mode_in = host;
    ref_halve_select_in = halve;
    reset_config_word_low_in = word;
    repeat (5) @(negedge mclk_in);
    resetn_in = 1'b1;
    repeat (8) @(negedge mclk_in);
  endtask : apply_reset
  // High samples of one watched output over n cycles
  task automatic count_high(input int idx, input int n, output int cnt);
    cnt = 0;
    repeat (n) begin
      @(negedge mclk_in);
      cnt = cnt + (watch[idx] === 1'b1);
    end
  endtask : count_high
  // Cycles between two rising edges, 0 when none within the bound
  task automatic period_of(input int idx, output int p);
    int n, rises, start;
    logic prev;
    n = 0;
    rises = 0;
    start = 0;
    p = 0;
    prev = watch[idx];
    while (rises < 2 && n < 200) begin
      @(negedge mclk_in);
      n = n + 1;
      if (prev === 1'b0 && watch[idx] === 1'b1) begin
        rises = rises + 1;
        if (rises == 1) start = n;
        else p = n - start;
      end
      prev = watch[idx];
    end
  endtask : period_of
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic ratio_sweep();
    logic [3:0] c;
    logic [4:0] ratio;
    int v;
    for (int k = 0; k < 16; k++) begin
      c = 4'(k);
      apply_reset(1'b1, c[0], {c[2], c[1], 2'h0, c, 1'h0, 7'(k + 3), 16'h0});
      ratio = (k < 2) ? 5'h0 : 5'((1 + c[0]) * k);
      check(cfg_loaded_out, 1'b1);
      check(system_pll_multiplier_reserved_out, k < 2);
      check(csb_ratio_out, ratio);
      check(core_pll_multiplier_out, 7'(k + 3));
      if (k >= 2) begin
        count_high(7, 24, v);
        check(v, c[1] ? 24 : 12);
        count_high(8, 24, v);
        check(v, c[1] ? 24 : 12);
        count_high(9, 24, v);
        check(v, c[2] ? 24 : 12);
        period_of(4, v);
        check(v, c[1] ? 2 : 4);
        check(memory_clock_out_b, {31'h0, ~memory_clock_out});
      end
    end
  endtask : ratio_sweep
  task automatic role_and_sync();
    int v;
    for (int h = 0; h < 2; h++) begin
      apply_reset(1'b1, h[0], {4'h0, 4'h4, 1'h0, 7'h4, 16'h0});
      bus_clock_out_enable_n_in = 3'h1;
      period_of(0, v);
      check(v, 16);
      period_of(1, v);
      check(v, h ? 32 : 16);
      period_of(2, v);
      check(v, h ? 32 : 16);
      count_high(3, 40, v);
      check(v, 0);
      check(sync_seen_out, 1'b1);
    end
    apply_reset(1'b0, 1'b0, {4'h0, 4'h4, 1'h0, 7'h4, 16'h0});
    period_of(0, v);
    check(v, 10);
  endtask : role_and_sync
  task automatic local_bus_div();
    int v;
    for (int m = 0; m < 2; m++) begin
      apply_reset(1'b1, 1'b0, {m[0], 3'h0, 4'h4, 1'h0, 7'h4, 16'h0});
      for (int d = 0; d < 4; d++) begin
        local_bus_divider_in = 2'(d);
        repeat (40) @(negedge mclk_in);
        period_of(5, v);
        check(v, 2 * (d == 0 ? 1 : d == 1 ? 2 : 4) * (m ? 1 : 2));
      end
    end
  endtask : local_bus_div
  task automatic unit_rates();
    int v;
    apply_reset(1'b1, 1'b0, {4'h0, 4'h4, 1'h0, 7'h4, 16'h0});
    for (int u = 0; u < 6; u++) begin
      count_high(10 + u, 24, v);
      check(v, u == 4 ? 12 : 4);
    end
    // full rate only at the twofold-slowed model rate
    for (int m = 0; m < 4; m++) begin
      peripheral_clock_ctrl_reg_in = {6{2'(m)}};
      repeat (20) @(negedge mclk_in);
      for (int u = 0; u < 6; u++) begin
        count_high(10 + u, 24, v);
        check(v, m == 0 ? 0 : (u == 4 || m == 1) ? 12 : m == 2 ? 6 : 4);
      end
    end
  endtask : unit_rates
  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : tally_and_finish
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    // straps sweep every system multiplier code, reserved ones included
    ratio_sweep();
    role_and_sync();
    local_bus_div();
    unit_rates();
    tally_and_finish();
  end
endmodule : system_clock_generation_tb_top
